// [cpt_adc_model.sv]
// Purpose: Behavioural converter stream that feeds samples to the engine.
// Assumes: Samples are launched just after a rising clock edge.
// Notes:   Data is inverted while no sample is offered, so stale values never match.
`timescale 1ns/1ps
`default_nettype none

module cpt_adc_model (
   // Clock.
   input  wire logic       clock,
   // Sample stream toward the engine.
   output var  logic       sample_valid,
   output var  logic [7:0] sample_data
);

   // -----------------------------------------------------------------
   // Stream driver
   // -----------------------------------------------------------------

   // Idle stream at time zero.
   initial begin
      sample_valid = 1'b0;
      sample_data  = 8'h5A;
   end

   // Offers one sample for one edge, then idles for gap cycles; gap 0 runs back to back.
   task automatic put(input logic [7:0] v, input int gap);
      sample_valid <= 1'b1;
      sample_data  <= v;
      @(posedge clock);
      if (gap > 0) begin
         sample_valid <= 1'b0;
         sample_data  <= ~v;
         repeat (gap) @(posedge clock);
      end
   endtask : put

endmodule : cpt_adc_model
`default_nettype wire

// [cpt_pkg.sv]
// Purpose: Shared constants and types of the channel pulse trigger engine.
// Assumes: Registers sit at word indices; byte address is four times the index.
// Notes:   Mode words are built from the single-bit flags below.
package cpt_pkg;

   // -------------------------------------------------------------------------
   // Register word indices
   // -------------------------------------------------------------------------
   localparam int          IDX_W            = 18;
   localparam int          ADDR_W           = IDX_W + 2;
   localparam logic [17:0] IDX_MODE         = 18'h09EA2;
   localparam logic [17:0] IDX_LEVEL_ZERO   = 18'h0A4D8;
   localparam logic [17:0] IDX_LEVEL_ONE    = 18'h0A53C;
   localparam logic [17:0] IDX_PULSE_LENGTH = 18'h0AC45;
   localparam logic [17:0] IDX_SOURCE_EN    = 18'h0B000;
   localparam logic [17:0] IDX_IRQ_STATUS   = 18'h0B001;
   localparam logic [17:0] IDX_IRQ_MASK     = 18'h0B002;

   // -------------------------------------------------------------------------
   // Mode word flags
   // -------------------------------------------------------------------------
   localparam logic [31:0] RISING_EDGE_FLAG    = 32'h0000_0001;
   localparam logic [31:0] FALLING_EDGE_FLAG   = 32'h0000_0002;
   localparam logic [31:0] SLOPE_UP_FLAG       = 32'h0000_0800;
   localparam logic [31:0] SLOPE_DOWN_FLAG     = 32'h0000_1000;
   localparam logic [31:0] HYSTERESIS_ARM_FLAG = 32'h0100_0000;
   localparam logic [31:0] SHORTER_THAN_FLAG   = 32'h0200_0000;
   localparam logic [31:0] LONGER_THAN_FLAG    = 32'h0400_0000;

   // -------------------------------------------------------------------------
   // Field layout, reset values and limits
   // -------------------------------------------------------------------------
   localparam int          SAMPLE_W       = 8;
   localparam int          SRC_W          = 4;
   localparam int          STAT_TRIGGER   = 0;
   localparam int          STAT_CFG_ERROR = 1;
   localparam int          STAT_W         = 2;
   localparam logic [31:0] MODE_RESET     = 32'h0000_0000;
   localparam logic [7:0]  LEVEL_RESET    = 8'h00;
   localparam logic [7:0]  LEVEL_MOST_NEG = 8'h80;
   localparam logic [7:0]  LEVEL_MIN      = 8'h81;
   localparam logic [15:0] PULSE_RESET    = 16'h0002;
   localparam logic [3:0]  SOURCE_RESET   = 4'h1;

   // Decoded operating mode of the engine.
   typedef enum logic [3:0] {
      CPT_IDLE, CPT_REARM_POS, CPT_REARM_NEG, CPT_LONG_POS, CPT_LONG_NEG,
      CPT_SHORT_POS, CPT_SHORT_NEG, CPT_FLAT_POS, CPT_FLAT_NEG, CPT_STEEP_POS
   } cpt_mode_t;

endpackage : cpt_pkg

// [cpt_trigger.sv]
// Purpose: Per-channel trigger engine with re-arm, pulsewidth and steepness modes.
// Assumes: Samples arrive from converter logic on the same clock, one per valid.
// Notes:   Registers are reached over APB; one interrupt output, W1C status.
`timescale 1ns/1ps
`default_nettype none

module cpt_trigger #(
   parameter int PW_W = 16
) (
   // Clock and reset.
   input  wire logic                        clock,
   input  wire logic                        rst,
   // APB slave.
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [cpt_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [31:0]                 pwdata,
   output var  logic [31:0]                 prdata,
   output var  logic                        pready,
   output var  logic                        pslverr,
   // Converter sample stream.
   input  wire logic                        sample_valid,
   input  wire logic [cpt_pkg::SAMPLE_W-1:0] sample_data,
   // Events.
   output var  logic                        trigger_event,
   output var  logic                        irq
);
   import cpt_pkg::*;

   // -------------------------------------------------------------------------
   // Elaboration checks
   // -------------------------------------------------------------------------
   if (PW_W < 2 || PW_W > 16) begin : g_bad_pw
      $error("PW_W must lie between 2 and 16.");
   end

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [31:0]         mode;
      logic [7:0]          lvl0;
      logic [7:0]          lvl1;
      logic [PW_W-1:0]     pw;
      logic [SRC_W-1:0]    srcen;
      logic [STAT_W-1:0]   mask;
      logic [STAT_W-1:0]   status;
      logic [7:0]          prev;
      logic                have_prev;
      logic                armed;
      logic                counting;
      logic [PW_W-1:0]     cnt;
      logic                trig;
      logic                irq;
      logic                pready;
      logic                pslverr;
      logic [31:0]         prdata;
   } cpt_state_t;

   cpt_state_t st_reg;
   cpt_state_t st_next;
   cpt_mode_t  mode_dec;
   logic [IDX_W-1:0] idx;
   logic       acc_done;
   logic       cfg_err;
   logic       step;
   logic       hit_lvl;
   logic signed [7:0] cur_s;
   logic signed [7:0] prev_s;
   logic signed [7:0] lo_s;
   logic signed [7:0] hi_s;
   logic       up_lo;
   logic       up_hi;
   logic       dn_lo;
   logic       dn_hi;
   logic       fire;
   logic       wr_mode;

   assign idx      = paddr[ADDR_W-1:2];
   assign acc_done = psel & penable & st_reg.pready;

   // Decodes the mode word; unsupported combinations leave the engine idle.
   always_comb begin
      unique case (st_reg.mode)
         RISING_EDGE_FLAG  | HYSTERESIS_ARM_FLAG: mode_dec = CPT_REARM_POS;
         FALLING_EDGE_FLAG | HYSTERESIS_ARM_FLAG: mode_dec = CPT_REARM_NEG;
         RISING_EDGE_FLAG  | LONGER_THAN_FLAG:    mode_dec = CPT_LONG_POS;
         FALLING_EDGE_FLAG | LONGER_THAN_FLAG:    mode_dec = CPT_LONG_NEG;
         RISING_EDGE_FLAG  | SHORTER_THAN_FLAG:   mode_dec = CPT_SHORT_POS;
         FALLING_EDGE_FLAG | SHORTER_THAN_FLAG:   mode_dec = CPT_SHORT_NEG;
         SLOPE_UP_FLAG     | LONGER_THAN_FLAG:    mode_dec = CPT_FLAT_POS;
         SLOPE_DOWN_FLAG   | LONGER_THAN_FLAG:    mode_dec = CPT_FLAT_NEG;
         SLOPE_UP_FLAG     | SHORTER_THAN_FLAG:   mode_dec = CPT_STEEP_POS;
         default:                                 mode_dec = CPT_IDLE;
      endcase
   end

   // Pulsewidth modes share one counter, so only one source may be enabled.
   always_comb begin
      cfg_err = 1'b0;
      if (mode_dec inside {CPT_LONG_POS, CPT_LONG_NEG, CPT_SHORT_POS, CPT_SHORT_NEG,
                           CPT_FLAT_POS, CPT_FLAT_NEG, CPT_STEEP_POS}) begin
         cfg_err = !$onehot0(st_reg.srcen);
      end
   end

   // Crossing detectors on consecutive samples against both levels.
   always_comb begin
      cur_s  = $signed(sample_data);
      prev_s = $signed(st_reg.prev);
      hi_s   = $signed(st_reg.lvl0);
      lo_s   = $signed(st_reg.lvl1);
      step   = sample_valid & st_reg.have_prev;
      up_lo  = step && (prev_s < lo_s) && (cur_s >= lo_s);
      up_hi  = step && (prev_s < hi_s) && (cur_s >= hi_s);
      dn_lo  = step && (prev_s >= lo_s) && (cur_s < lo_s);
      dn_hi  = step && (prev_s >= hi_s) && (cur_s < hi_s);
   end

   // -------------------------------------------------------------------------
   // Next-state logic
   // -------------------------------------------------------------------------
   // Fills the next state: bus slave, trigger engine and interrupt status.
   always_comb begin
      st_next = st_reg;
      fire    = 1'b0;
      hit_lvl = 1'b0;
      wr_mode = 1'b0;

      // APB: one wait state, answer registered with the read data.
      st_next.pready  = psel & penable & ~st_reg.pready;
      st_next.pslverr = 1'b0;
      if (psel & penable & ~st_reg.pready) begin
         st_next.prdata = 32'h0000_0000;
         unique case (idx)
            IDX_MODE:         st_next.prdata = st_reg.mode;
            IDX_LEVEL_ZERO:   st_next.prdata = {24'h00_0000, st_reg.lvl0};
            IDX_LEVEL_ONE:    st_next.prdata = {24'h00_0000, st_reg.lvl1};
            IDX_PULSE_LENGTH: st_next.prdata = {{(32-PW_W){1'b0}}, st_reg.pw};
            IDX_SOURCE_EN:    st_next.prdata = {28'h000_0000, st_reg.srcen};
            IDX_IRQ_STATUS:   st_next.prdata = {30'h0000_0000, st_reg.status};
            IDX_IRQ_MASK:     st_next.prdata = {30'h0000_0000, st_reg.mask};
            default:          st_next.pslverr = 1'b1;
         endcase
      end

      // Trigger engine, stepped once per valid sample.
      if (sample_valid) begin
         st_next.prev      = sample_data;
         st_next.have_prev = 1'b1;
      end
      if (step && !cfg_err) begin
         unique case (mode_dec)
            CPT_REARM_POS: begin
               if (st_reg.armed && up_hi) begin
                  fire           = 1'b1;
                  st_next.armed  = 1'b0;
               end else if (up_lo) begin
                  st_next.armed  = 1'b1;
               end
            end
            CPT_REARM_NEG: begin
               if (st_reg.armed && dn_lo) begin
                  fire           = 1'b1;
                  st_next.armed  = 1'b0;
               end else if (dn_hi) begin
                  st_next.armed  = 1'b1;
               end
            end
            CPT_LONG_POS, CPT_LONG_NEG, CPT_SHORT_POS, CPT_SHORT_NEG: begin
               if (!st_reg.counting) begin
                  if ((mode_dec inside {CPT_LONG_POS, CPT_SHORT_POS}) ? up_hi : dn_hi) begin
                     st_next.counting = 1'b1;
                     st_next.cnt      = {{(PW_W-1){1'b0}}, 1'b1};
                  end
               end else begin
                  hit_lvl = (mode_dec inside {CPT_LONG_POS, CPT_SHORT_POS}) ? dn_hi : up_hi;
                  if (hit_lvl) begin
                     st_next.counting = 1'b0;
                     fire = (mode_dec inside {CPT_SHORT_POS, CPT_SHORT_NEG});
                  end else if (st_reg.cnt + 1'b1 == st_reg.pw) begin
                     st_next.counting = 1'b0;
                     fire = (mode_dec inside {CPT_LONG_POS, CPT_LONG_NEG});
                  end else begin
                     st_next.cnt = st_reg.cnt + 1'b1;
                  end
               end
            end
            CPT_FLAT_POS, CPT_FLAT_NEG, CPT_STEEP_POS: begin
               if (!st_reg.counting) begin
                  if ((mode_dec == CPT_FLAT_NEG) ? dn_hi : up_lo) begin
                     st_next.counting = 1'b1;
                     st_next.cnt      = {{(PW_W-1){1'b0}}, 1'b1};
                  end
               end else begin
                  hit_lvl = (mode_dec == CPT_FLAT_NEG) ? dn_lo : up_hi;
                  if (hit_lvl) begin
                     st_next.counting = 1'b0;
                     fire = (mode_dec == CPT_STEEP_POS);
                  end else if (st_reg.cnt + 1'b1 == st_reg.pw) begin
                     st_next.counting = 1'b0;
                     fire = (mode_dec != CPT_STEEP_POS);
                  end else begin
                     st_next.cnt = st_reg.cnt + 1'b1;
                  end
               end
            end
            CPT_IDLE: begin
               st_next.counting = 1'b0;
               st_next.armed    = 1'b0;
            end
         endcase
      end
      if (cfg_err) begin
         st_next.counting = 1'b0;
         st_next.armed    = 1'b0;
      end

      // Register writes take effect at the completing access edge.
      if (acc_done && pwrite) begin
         unique case (idx)
            IDX_MODE: begin
               st_next.mode = pwdata;
               wr_mode      = 1'b1;
            end
            IDX_LEVEL_ZERO: begin
               st_next.lvl0 = (pwdata[7:0] == LEVEL_MOST_NEG) ? LEVEL_MIN : pwdata[7:0];
            end
            IDX_LEVEL_ONE: begin
               st_next.lvl1 = (pwdata[7:0] == LEVEL_MOST_NEG) ? LEVEL_MIN : pwdata[7:0];
            end
            IDX_PULSE_LENGTH: begin
               st_next.pw       = pwdata[PW_W-1:0];
               st_next.counting = 1'b0; // Restart, so the count never passes a shorter length.
            end
            IDX_SOURCE_EN:    st_next.srcen = pwdata[SRC_W-1:0];
            IDX_IRQ_STATUS:   st_next.status = st_reg.status & ~pwdata[STAT_W-1:0];
            IDX_IRQ_MASK:     st_next.mask  = pwdata[STAT_W-1:0];
            default: ;
         endcase
      end
      // A new mode starts from a disarmed, stopped engine.
      if (wr_mode) begin
         st_next.armed    = 1'b0;
         st_next.counting = 1'b0;
      end

      // Events set status after any clear, so a set in the clear cycle wins.
      st_next.trig = fire;
      if (fire) begin
         st_next.status[STAT_TRIGGER] = 1'b1;
      end
      if (cfg_err) begin
         st_next.status[STAT_CFG_ERROR] = 1'b1;
      end
      st_next.irq = |(st_next.status & st_next.mask);
   end

   // -------------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------------
   // Registers the whole state; reset loads constants only.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_reg           <= '0;
         st_reg.mode      <= MODE_RESET;
         st_reg.lvl0      <= LEVEL_RESET;
         st_reg.lvl1      <= LEVEL_RESET;
         st_reg.pw        <= PULSE_RESET[PW_W-1:0];
         st_reg.srcen     <= SOURCE_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs come straight from the state flip-flops.
   assign prdata        = st_reg.prdata;
   assign pready        = st_reg.pready;
   assign pslverr       = st_reg.pslverr;
   assign trigger_event = st_reg.trig;
   assign irq           = st_reg.irq;

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   property p_eval_on_sample;
      trigger_event |-> $past(sample_valid);
   endproperty
   a_eval_on_sample: assert property (p_eval_on_sample)
      else $error("Trigger raised without a sample.");
   property p_rearm_pos_arm;
      (mode_dec == CPT_REARM_POS && !cfg_err && !st_reg.armed && up_lo && !wr_mode)
         |=> st_reg.armed;
   endproperty
   a_rearm_pos_arm: assert property (p_rearm_pos_arm)
      else $error("Positive re-arm crossing did not arm.");
   property p_rearm_neg_fire;
      (mode_dec == CPT_REARM_NEG && !cfg_err && st_reg.armed && dn_lo)
         |=> trigger_event && !st_reg.armed;
   endproperty
   a_rearm_neg_fire: assert property (p_rearm_neg_fire)
      else $error("Negative re-arm fire or disarm missing.");
   property p_disarmed_silent;
      (mode_dec inside {CPT_REARM_POS, CPT_REARM_NEG}) && !st_reg.armed |=> !trigger_event;
   endproperty
   a_disarmed_silent: assert property (p_disarmed_silent)
      else $error("Trigger while disarmed.");
   property p_long_expiry;
      (mode_dec == CPT_LONG_POS && !cfg_err && st_reg.counting && step && !dn_hi &&
       st_reg.cnt + 1'b1 == st_reg.pw && !wr_mode) |=> trigger_event && !st_reg.counting;
   endproperty
   a_long_expiry: assert property (p_long_expiry)
      else $error("Long pulse expiry did not trigger.");
   property p_long_cancel;
      (mode_dec == CPT_LONG_NEG && st_reg.counting && up_hi) |=> !trigger_event;
   endproperty
   a_long_cancel: assert property (p_long_cancel)
      else $error("Cancelled long pulse triggered.");
   property p_short_fire;
      (mode_dec == CPT_SHORT_POS && !cfg_err && st_reg.counting && dn_hi)
         |=> trigger_event ##1 !trigger_event;
   endproperty
   a_short_fire: assert property (p_short_fire)
      else $error("Short pulse did not give one trigger pulse.");

   property p_short_expiry;
      (mode_dec == CPT_SHORT_NEG && st_reg.counting && !up_hi) |=> !trigger_event;
   endproperty
   a_short_expiry: assert property (p_short_expiry)
      else $error("Short pulse expiry triggered.");

   property p_steep_fire;
      (mode_dec == CPT_STEEP_POS && !cfg_err && st_reg.counting && up_hi) |=> trigger_event;
   endproperty
   a_steep_fire: assert property (p_steep_fire)
      else $error("Steep crossing did not trigger.");

   property p_flat_cancel;
      (mode_dec inside {CPT_FLAT_POS, CPT_FLAT_NEG}) && st_reg.counting &&
      ((mode_dec == CPT_FLAT_POS) ? up_hi : dn_lo) |=> !trigger_event && !st_reg.counting;
   endproperty
   a_flat_cancel: assert property (p_flat_cancel)
      else $error("Flat pulse cancel crossing not honoured.");

   property p_single_source;
      cfg_err |=> !st_reg.counting && st_reg.status[STAT_CFG_ERROR];
   endproperty
   a_single_source: assert property (p_single_source)
      else $error("Several sources not rejected.");

   property p_level_range;
      st_reg.lvl0 != LEVEL_MOST_NEG && st_reg.lvl1 != LEVEL_MOST_NEG;
   endproperty
   a_level_range: assert property (p_level_range)
      else $error("Level outside the signed range.");

   property p_cnt_bound;
      st_reg.counting && st_reg.pw >= 2 |-> st_reg.cnt < st_reg.pw;
   endproperty
   a_cnt_bound: assert property (p_cnt_bound)
      else $error("Pulse counter passed its length.");

   property p_apb_pulse;
      pready |=> !pready;
   endproperty
   a_apb_pulse: assert property (p_apb_pulse)
      else $error("Ready held for more than one cycle.");

   c_rearm_fire: cover property (mode_dec == CPT_REARM_POS ##1 trigger_event);
   c_long_fire:  cover property (mode_dec == CPT_LONG_POS && st_reg.counting ##[1:20] trigger_event);
   c_flat_fire:  cover property (mode_dec == CPT_FLAT_NEG && st_reg.counting ##[1:20] trigger_event);
   c_irq:        cover property ($rose(irq));

endmodule : cpt_trigger

`default_nettype wire

// [cpt_unused_placeholder_never.sv]
// Purpose: Empty source unit kept beside the trigger engine.
// Assumes: Nothing is declared here.
// Notes:   All logic of the block lives in the engine file.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [tb.sv]
// Purpose: Self-checking bench of the channel trigger engine.
// Assumes: APB answers within a bounded wait; a trigger pulse follows its sample by one edge.
// Notes:   A step function predicts every trigger pulse from the sample stream.
`timescale 1ns/1ps
`default_nettype none

module tb;
   import cpt_pkg::*;

   // -----------------------------------------------------------------
   // Signals and reference state
   // -----------------------------------------------------------------
   logic               clock, rst, psel, penable, pwrite, pready, pslverr;
   logic [19:0]        paddr;
   logic [31:0]        pwdata, prdata, seed, r;
   logic               sample_valid, trigger_event, irq, e, exp_q;
   logic [7:0]         sample_data;
   logic signed [7:0]  pv, l0, l1;
   logic               hv, arm, cnt_on, halted;
   logic [31:0]        md;
   int                 cnt, pw, fails, n_tests, x, p;
   logic [31:0] mt [9] = '{32'h0100_0001, 32'h0100_0002,
      32'h0400_0001, 32'h0400_0002, 32'h0200_0001, 32'h0200_0002,
      32'h0400_0800, 32'h0400_1000, 32'h0200_0800};

   cpt_trigger #(.PW_W(16)) cpt_trigger_inst (.clock(clock), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
      .sample_data(sample_data), .trigger_event(trigger_event), .irq(irq));

   cpt_adc_model cpt_adc_model_inst (.clock(clock), .sample_valid(sample_valid),
      .sample_data(sample_data));

   // Free-running 200 MHz clock.
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------

   // Xorshift source with a fixed seed.
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // Predicts whether this sample raises a trigger.
   function automatic logic step(input logic signed [7:0] s);
      logic f, u0, d0, u1, d1, st, en;
      f  = 1'b0;
      st = 1'b0;
      en = 1'b0;
      u0 = hv && pv < l0 && s >= l0;
      d0 = hv && pv >= l0 && s < l0;
      u1 = hv && pv < l1 && s >= l1;
      d1 = hv && pv >= l1 && s < l1;
      case (md)
         32'h0100_0001: if (arm && u0) {f, arm} = 2'b10; else if (u1) arm = 1'b1;
         32'h0100_0002: if (arm && d1) {f, arm} = 2'b10; else if (d0) arm = 1'b1;
         32'h0400_0001, 32'h0200_0001: {st, en} = {u0, d0};
         32'h0400_0002, 32'h0200_0002: {st, en} = {d0, u0};
         32'h0400_0800, 32'h0200_0800: {st, en} = {u1, u0};
         32'h0400_1000: {st, en} = {d0, d1};
         default: ;
      endcase
      if (cnt_on) begin
         cnt++;
         if (en) {cnt_on, f} = {1'b0, md[25]};
         else if (cnt == pw) {cnt_on, f} = {1'b0, md[26]};
      end else if (st) begin
         cnt_on = 1'b1;
         cnt    = 1;
      end
      pv = s;
      hv = 1'b1;
      return f && !halted;
   endfunction : step

   // Counts a comparison and reports a mismatch.
   task automatic chk(input logic [31:0] s, input logic [31:0] ex);
      n_tests++;
      if (s !== ex) begin
         fails++;
         $display("wrong value at %0t: seen %h, expected %h", $time, s, ex);
      end
   endtask : chk

   // Prints the verdict and stops.
   task automatic end_of_test();
      if (fails == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   // One APB transfer; holds the request until pready is seen high.
   task automatic apb(input logic w, input logic [17:0] i, input logic [31:0] d);
      int k;
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= {i, 2'b00};
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (pready !== 1'b1 && k < 50);
      r = prdata;
      e = pslverr;
      if (k >= 50) begin
         fails++;
         end_of_test();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask : apb

   task automatic wr(input logic [17:0] i, input logic [31:0] d);
      apb(1'b1, i, d);
      chk(32'(e), 32'h0);
   endtask : wr

   task automatic rd(input logic [17:0] i, input logic [31:0] ex);
      apb(1'b0, i, 32'h0);
      chk(r, ex);
      chk(32'(e), 32'h0);
   endtask : rd

   // Programs levels, pulse length and mode, and clears the predicted state.
   task automatic cfg(input logic [31:0] m, input logic [7:0] a, b, input int q);
      wr(IDX_LEVEL_ZERO, {24'h0, a});
      wr(IDX_LEVEL_ONE, {24'h0, b});
      wr(IDX_PULSE_LENGTH, 32'(q));
      rd(IDX_PULSE_LENGTH, 32'(q));
      wr(IDX_MODE, m);
      {l0, l1, pw, md, arm, cnt_on} = {a, b, q, m, 2'b00};
   endtask : cfg

   // Every edge compares the trigger pulse with the prediction of the previous edge.
   always @(posedge clock) begin
      if (!rst) begin
         chk(32'(trigger_event), 32'(exp_q));
         exp_q <= sample_valid ? step(sample_data) : 1'b0;
      end else exp_q <= 1'b0;
   end

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 52'h0};
      {seed, hv, arm, cnt_on, halted, md, exp_q} = {32'h0000_BA3B, 37'h0};
      {fails, n_tests, cnt, pw} = 0;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      // Reset values, unmapped access and the excluded most negative level.
      rd(IDX_MODE, 32'h0);
      rd(IDX_LEVEL_ZERO, 32'h0);
      rd(IDX_PULSE_LENGTH, 32'h2);
      rd(IDX_SOURCE_EN, 32'h1);
      rd(IDX_IRQ_MASK, 32'h0);
      apb(1'b1, 18'h00001, 32'hFFFF_FFFF);
      chk(32'(e), 32'h1);
      apb(1'b0, 18'h00001, 32'h0);
      chk({r[30:0], e}, 32'h1);
      wr(IDX_LEVEL_ONE, 32'hFFFF_FF80);
      rd(IDX_LEVEL_ONE, 32'h81);
      // Every mode against a random walk with random gaps.
      for (int m = 0; m < 18; m++) begin
         p  = (m < 9) ? 2 : 2 + int'(rnd() % 6);
         l1 = 8'(-int'(rnd() % 100));
         l0 = 8'(int'(l1) + 20 + int'(rnd() % 60));
         cfg(mt[m % 9], l0, l1, p);
         x = int'(l1) - 10;
         for (int n = 0; n < 80; n++) begin
            x = x + int'(rnd() % 16) - 8;
            x = (x > 127) ? 127 : (x < -127) ? -127 : x;
            cpt_adc_model_inst.put(8'(x), (n == 79) ? 1 : int'(rnd() % 3));
         end
         repeat (2) @(posedge clock);
      end
      // Interrupt raised, masked and cleared; third crossing only re-arms.
      wr(IDX_IRQ_STATUS, 32'h3);
      wr(IDX_IRQ_MASK, 32'h1);
      cfg(32'h0100_0001, 8'h0A, 8'hF6, 2);
      chk(32'(irq), 32'h0);
      foreach (mt[k]) if (k < 6) cpt_adc_model_inst.put(k[0] ? 8'h14 : 8'hEC, k);
      repeat (3) @(posedge clock);
      chk(32'(irq), 32'h1);
      rd(IDX_IRQ_STATUS, 32'h1);
      wr(IDX_IRQ_MASK, 32'h0);
      @(posedge clock);
      chk(32'(irq), 32'h0);
      wr(IDX_IRQ_STATUS, 32'h1);
      rd(IDX_IRQ_STATUS, 32'h0);
      // A plain edge word is unsupported here, so the engine stays idle.
      cfg(RISING_EDGE_FLAG, 8'h0A, 8'hF6, 2);
      for (int k = 0; k < 4; k++) cpt_adc_model_inst.put(k[0] ? 8'h14 : 8'hEC, 1);
      // Two sources with a pulsewidth mode are refused.
      halted = 1'b1;
      wr(IDX_SOURCE_EN, 32'h3);
      cfg(32'h0400_0001, 8'h0A, 8'hF6, 2);
      for (int k = 0; k < 4; k++) cpt_adc_model_inst.put(k ? 8'h14 : 8'hEC, 1);
      rd(IDX_IRQ_STATUS, 32'h2);
      wr(IDX_IRQ_MASK, 32'h2);
      @(posedge clock);
      chk(32'(irq), 32'h1);
      end_of_test();
   end

endmodule : tb
`default_nettype wire
